// File: hdl/psram_cfg_controller.sv
// Purpose: Memory controller end: APB-programmed single, burst, pin
//          register and software-sequence operations on the link.
// Assumes: DIV pclk cycles per link phase, enough to cover both syncs.
// Notes:   One operation at a time; CTRL writes while busy are dropped.
`timescale 1ns/1ns
module psram_cfg_controller #(
  parameter int DIV = 8
) (
  psram_link_if.controller link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [2:0] {C_IDLE, C_ADDR, C_LATCH, C_ACT, C_BEAT_HI, C_FINISH, C_GAP} ctl_state_t;

  ctl_state_t  state_q;
  logic [7:0]  div_q;
  logic [31:0] ctrl_q;
  logic [22:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        busy_q;
  logic [1:0]  step_q;
  logic [7:0]  beat_q;
  logic [15:0] rd1_q;
  logic [15:0] rd2_q;
  logic        lclk_q, cs_n_q, avld_n_q, we_n_q, oe_n_q, rsel_q, doe_n_q;
  logic [6:0]  hi_q;
  logic [15:0] dout_q;

  // APB decode
  wire access  = psel && penable;
  wire sel_c   = paddr == psram_cfg_pkg::REG_CTRL;
  wire sel_a   = paddr == psram_cfg_pkg::REG_ADDR;
  wire sel_w   = paddr == psram_cfg_pkg::REG_WDATA;
  wire sel_r   = paddr == psram_cfg_pkg::REG_RDATA;
  wire sel_s   = paddr == psram_cfg_pkg::REG_STATUS;
  wire hit     = sel_c || sel_a || sel_w || sel_r || sel_s;
  wire wr_en   = access && pready && pwrite && hit;
  wire start   = wr_en && sel_c && !busy_q;
  wire [31:0] rd_mux = sel_c ? ctrl_q : sel_a ? {9'h000, addr_q} : sel_w ? {16'h0000, wdata_q} :
                       sel_r ? {16'h0000, rdata_q} : sel_s ? {29'h00000000, step_q, busy_q} : 32'h00000000;

  // Current operation decode
  wire        tick     = div_q == 8'(DIV - 1);
  psram_cfg_pkg::link_op_t op;
  assign op = psram_cfg_pkg::link_op_t'(ctrl_q[psram_cfg_pkg::CTRL_OP_LSB +: 3]);
  wire        is_sw    = op == psram_cfg_pkg::OP_SW_LOAD || op == psram_cfg_pkg::OP_SW_READ;
  wire        sel_step = is_sw && step_q == 2'h2;
  wire        cur_wr   = op == psram_cfg_pkg::OP_ARRAY_WR || op == psram_cfg_pkg::OP_PIN_WR ||
                         op == psram_cfg_pkg::OP_BURST_WR || sel_step ||
                         (op == psram_cfg_pkg::OP_SW_LOAD && step_q == 2'h3);
  wire        cur_rsel = op == psram_cfg_pkg::OP_PIN_RD || op == psram_cfg_pkg::OP_PIN_WR;
  wire        cur_bst  = op == psram_cfg_pkg::OP_BURST_RD || op == psram_cfg_pkg::OP_BURST_WR;
  wire [22:0] cur_addr = is_sw ? psram_cfg_pkg::TOP_ADDR : addr_q;
  wire [15:0] cur_data = sel_step ? (ctrl_q[psram_cfg_pkg::CTRL_SWSEL_BIT] ? psram_cfg_pkg::SW_SEL_BUS :
                         psram_cfg_pkg::SW_SEL_REFRESH) : wdata_q;
  wire [7:0]  beats    = (ctrl_q[psram_cfg_pkg::CTRL_BEATS_LSB +: 8] == 8'h00) ? 8'h01 :
                         ctrl_q[psram_cfg_pkg::CTRL_BEATS_LSB +: 8];
  wire        last     = !is_sw || step_q == 2'h3;

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= rd_mux;
      pslverr <= access && !pready && !hit;
    end
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 32'h00000000;
      addr_q  <= 23'h000000;
      wdata_q <= 16'h0000;
    end else begin
      if (start) ctrl_q <= pwdata;
      if (wr_en && sel_a) addr_q <= pwdata[22:0];
      if (wr_en && sel_w) wdata_q <= pwdata[15:0];
    end
  end

  // Phase divider and read data synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      rd1_q <= 16'h0000;
      rd2_q <= 16'h0000;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      rd1_q <= link.muxed_addr_data;
      rd2_q <= rd1_q;
    end
  end

  // Link sequencer, one phase per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= C_IDLE;
      busy_q  <= 1'b0;
      step_q  <= 2'h0;
      beat_q  <= 8'h00;
      rdata_q <= 16'h0000;
      lclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      avld_n_q <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      rsel_q  <= 1'b0;
      doe_n_q <= 1'b1;
      hi_q    <= 7'h00;
      dout_q  <= 16'h0000;
    end else if (start) begin
      busy_q <= 1'b1;
      step_q <= 2'h0;
    end else if (tick) begin
      case (state_q)
        C_IDLE: if (busy_q) begin
          cs_n_q            <= 1'b0;
          avld_n_q          <= 1'b0;
          rsel_q            <= cur_rsel;
          {hi_q, dout_q}    <= cur_addr;
          doe_n_q           <= 1'b0;
          state_q           <= C_ADDR;
        end
        C_ADDR: begin
          avld_n_q <= 1'b1;
          doe_n_q <= 1'b1;
          state_q <= C_LATCH;
        end
        C_LATCH: begin
          we_n_q  <= !cur_wr;
          oe_n_q  <= cur_wr;
          doe_n_q <= !cur_wr;
          dout_q  <= cur_data;
          beat_q  <= 8'h00;
          state_q <= C_ACT;
        end
        C_ACT: if (cur_bst) begin
          rdata_q <= rd2_q;
          lclk_q  <= 1'b1;
          beat_q  <= beat_q + 8'h01;
          state_q <= C_BEAT_HI;
        end else begin
          state_q <= C_FINISH;
        end
        C_BEAT_HI: begin
          lclk_q  <= 1'b0;
          dout_q  <= wdata_q + {8'h00, beat_q};
          state_q <= (beat_q == beats) ? C_FINISH : C_ACT;
        end
        C_FINISH: begin
          if (!cur_bst && !cur_wr) rdata_q <= rd2_q;
          we_n_q  <= 1'b1;
          oe_n_q  <= 1'b1;
          state_q <= C_GAP;
        end
        C_GAP: begin
          cs_n_q  <= 1'b1;
          doe_n_q <= 1'b1;
          rsel_q  <= 1'b0;
          busy_q  <= !last;
          step_q  <= last ? 2'h0 : step_q + 2'h1;
          state_q <= C_IDLE;
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end

  assign link.link_clk            = lclk_q;
  assign link.cs_n                = cs_n_q;
  assign link.address_valid_n     = avld_n_q;
  assign link.we_n                = we_n_q;
  assign link.oe_n                = oe_n_q;
  assign link.register_select_pin = rsel_q;
  assign link.addr_hi             = hi_q;
  assign link.ctl_data_out        = dout_q;
  assign link.ctl_data_oe_n       = doe_n_q;
endmodule : psram_cfg_controller

// File: hdl/psram_cfg_device.sv
// Purpose: PSRAM end: register access by pin or software sequence,
//          burst address sequencing and a small array.
// Assumes: All link pins are asynchronous to pclk and pass two flops.
// Notes:   Array depth is a parameter; upper address bits alias.
`timescale 1ns/1ns
module psram_cfg_device #(
  parameter int          MEM_AW   = 10,
  parameter logic [15:0] ID_VALUE = 16'h5A5A // Arbitrary identification value
) (
  psram_link_if.device  link,
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic [15:0]      bus_configuration_q,
  output logic [15:0]      refresh_configuration_q
);
  localparam int HI_W   = psram_cfg_pkg::HI_W;
  localparam int DATA_W = psram_cfg_pkg::DATA_W;
  localparam int SW     = 6 + HI_W + DATA_W;

  typedef enum logic [1:0] {SW_IDLE, SW_READ1, SW_READ2, SW_SELECTED} sw_step_t;

  logic [SW-1:0]                   sync1_q;
  logic [SW-1:0]                   sync2_q;
  logic [SW-1:0]                   prev_q;
  logic [psram_cfg_pkg::ADDR_W-1:0] addr_q;
  logic                            op_reg_q;
  logic                            beats_q;
  logic                            op_rd_q;
  logic                            op_wr_q;
  sw_step_t                        step_q;
  logic [15:0]                     sw_sel_q;
  logic [15:0]                     dev_out_q;
  logic                            dev_oe_n_q;
  logic [15:0]                     mem [0:(1<<MEM_AW)-1];

  // Pin sampling, two flops then one more for edge finding
  wire [SW-1:0] pins_in = {link.link_clk, link.cs_n, link.address_valid_n, link.we_n, link.oe_n,
                           link.register_select_pin, link.addr_hi, link.muxed_addr_data};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Decoded pin levels and edges
  wire              s_clk  = sync2_q[SW-1];
  wire              s_cs_n = sync2_q[SW-2];
  wire              s_avld_n = sync2_q[SW-3];
  wire              s_we_n   = sync2_q[SW-4];
  wire              s_oe_n   = sync2_q[SW-5];
  wire              s_rsel   = sync2_q[SW-6];
  wire [HI_W-1:0]   s_hi   = sync2_q[DATA_W +: HI_W];
  wire [DATA_W-1:0] s_data = sync2_q[DATA_W-1:0];
  wire cs_fall  = prev_q[SW-2] & !s_cs_n;
  wire cs_rise  = !prev_q[SW-2] & s_cs_n;
  wire addr_phase = !s_avld_n & !s_cs_n; // Lines are released as the phase ends
  wire we_fall  = prev_q[SW-4] & !s_we_n & !s_cs_n;
  wire we_rise  = !prev_q[SW-4] & s_we_n;
  wire oe_fall  = prev_q[SW-5] & !s_oe_n & !s_cs_n;
  wire clk_rise = !prev_q[SW-1] & s_clk & !s_cs_n;

  // Access classification
  wire [1:0] pin_sel  = addr_q[psram_cfg_pkg::PIN_SEL_LSB +: 2];
  wire       at_top   = !op_reg_q && !beats_q && addr_q == psram_cfg_pkg::TOP_ADDR;
  wire       sw_slot  = at_top && (step_q == SW_READ2 || step_q == SW_SELECTED);
  wire       sw_final = at_top && step_q == SW_SELECTED;
  wire       op_read  = op_rd_q && !op_wr_q;
  wire       op_write = op_wr_q && !op_rd_q;
  wire       single_wr_end = we_rise && !beats_q;
  wire       arr_wr   = !op_reg_q && !sw_slot && (single_wr_end || (clk_rise && !s_we_n));
  wire       burst_step = clk_rise && (!s_we_n || !s_oe_n);

  // Register and array read selection
  wire [15:0] sw_reg_word  = (sw_sel_q == psram_cfg_pkg::SW_SEL_REFRESH) ? refresh_configuration_q :
                             (sw_sel_q == psram_cfg_pkg::SW_SEL_BUS) ? bus_configuration_q : 16'h0000;
  wire [15:0] pin_reg_word = (pin_sel == psram_cfg_pkg::PIN_SEL_REFRESH) ? refresh_configuration_q :
                             (pin_sel == psram_cfg_pkg::PIN_SEL_BUS) ? bus_configuration_q :
                             (pin_sel == psram_cfg_pkg::PIN_SEL_ID)  ? ID_VALUE : 16'h0000;
  wire [15:0] rd_word      = op_reg_q ? pin_reg_word :
                             (sw_final ? sw_reg_word : mem[addr_q[MEM_AW-1:0]]);

  // Operation address, type and burst stepping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q   <= '0;
      op_reg_q <= 1'b0;
      beats_q  <= 1'b0;
      op_rd_q  <= 1'b0;
      op_wr_q  <= 1'b0;
    end else begin
      if (cs_fall) begin
        op_rd_q <= 1'b0;
        op_wr_q <= 1'b0;
        beats_q <= 1'b0;
      end
      if (oe_fall) op_rd_q <= 1'b1;
      if (we_fall) op_wr_q <= 1'b1;
      if (burst_step) beats_q <= 1'b1;
      if (addr_phase) begin
        addr_q   <= {s_hi, s_data};
        op_reg_q <= s_rsel;
      end else if (burst_step) begin
        addr_q <= psram_cfg_pkg::next_word_addr(addr_q, bus_configuration_q);
      end
    end
  end

  // Software sequence tracking, checked at each operation end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q   <= SW_IDLE;
      sw_sel_q <= 16'h0000;
    end else begin
      if (single_wr_end && at_top && step_q == SW_READ2) sw_sel_q <= s_data;
      if (cs_rise) begin
        case (step_q)
          SW_IDLE:     step_q <= (at_top && op_read) ? SW_READ1 : SW_IDLE;
          SW_READ1:    step_q <= (at_top && op_read) ? SW_READ2 : SW_IDLE;
          SW_READ2:    step_q <= (at_top && op_write) ? SW_SELECTED :
                                 ((at_top && op_read) ? SW_READ2 : SW_IDLE);
          SW_SELECTED: step_q <= SW_IDLE;
          default:     step_q <= SW_IDLE;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_configuration_q     <= psram_cfg_pkg::BUS_CFG_RESET;
      refresh_configuration_q <= psram_cfg_pkg::REFRESH_CFG_RESET;
    end else if (single_wr_end && op_reg_q) begin
      if (pin_sel == psram_cfg_pkg::PIN_SEL_REFRESH) refresh_configuration_q <= s_data;
      if (pin_sel == psram_cfg_pkg::PIN_SEL_BUS) bus_configuration_q <= s_data;
    end else if (single_wr_end && sw_final) begin
      if (sw_sel_q == psram_cfg_pkg::SW_SEL_REFRESH) refresh_configuration_q <= s_data;
      if (sw_sel_q == psram_cfg_pkg::SW_SEL_BUS) bus_configuration_q <= s_data;
    end
  end

  // Data line drive during reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_out_q  <= 16'h0000;
      dev_oe_n_q <= 1'b1;
    end else begin
      dev_out_q  <= rd_word;
      dev_oe_n_q <= s_cs_n || s_oe_n || !s_avld_n;
    end
  end

  // Array write port
  always_ff @(posedge pclk) begin
    if (arr_wr) mem[addr_q[MEM_AW-1:0]] <= s_data;
  end

  assign link.dev_data_out  = dev_out_q;
  assign link.dev_data_oe_n = dev_oe_n_q;
endmodule : psram_cfg_device

// File: hdl/psram_cfg_pkg.sv
// Purpose: Shared constants, types and burst address step for the PSRAM
//          configuration-register link and its controller.
// Assumes: 16-bit multiplexed address/data, 23-bit word address.
// Notes:   Overview of operation list below.
//
// Overview of operation
// - Load: two reads, then two writes
// - Read: same, fourth operation is a read
// - Sequence hits top address, array untouched
// - Third write data 0 refresh, 1 bus
// - Fourth operation moves all sixteen bits
// - Pin and software access both stay usable
// - Pin read: 00 refresh, 10 bus, 01 ident
// - Pin write: 00 refresh, 10 bus
// - Sync register write keeps select low
// - Sync register read keeps select low
// - Bus configuration resets to 9D1F
// - Reserved bits zero, readback as written
// - Burst length 4/8/16/32 or continuous
// - Continuous burst rolls over past end
// - Wrap on: step inside aligned block
// - Wrap off: plain sequential addresses
// - Length and wrap govern writes too
// - Select pin high: registers, low: array
// - Identification register ignores writes
// - Update registers only from standby
package psram_cfg_pkg;
  localparam int ADDR_W = 23;
  localparam int HI_W   = 7;
  localparam int DATA_W = 16;

  // Device register reset values
  localparam logic [15:0] BUS_CFG_RESET     = 16'h9D1F;
  localparam logic [15:0] REFRESH_CFG_RESET = 16'h0010;

  // Field positions
  localparam int WRAP_BIT    = 3;
  localparam int PIN_SEL_LSB  = 18;

  // Pin-method register select codes on A[19:18]
  localparam logic [1:0] PIN_SEL_REFRESH = 2'h0;
  localparam logic [1:0] PIN_SEL_ID      = 2'h1;
  localparam logic [1:0] PIN_SEL_BUS     = 2'h2;

  // Software-sequence selector words
  localparam logic [15:0] SW_SEL_REFRESH = 16'h0000;
  localparam logic [15:0] SW_SEL_BUS     = 16'h0001;

  localparam logic [ADDR_W-1:0] TOP_ADDR = 23'h7FFFFF;

  // Burst length decode table: code and block mask
  localparam logic [2:0] BL_CODE_4  = 3'h1;
  localparam logic [2:0] BL_CODE_8  = 3'h2;
  localparam logic [2:0] BL_CODE_16 = 3'h3;
  localparam logic [2:0] BL_CODE_32 = 3'h4;
  localparam logic [ADDR_W-1:0] BL_MASK_4  = 23'h000003;
  localparam logic [ADDR_W-1:0] BL_MASK_8  = 23'h000007;
  localparam logic [ADDR_W-1:0] BL_MASK_16 = 23'h00000F;
  localparam logic [ADDR_W-1:0] BL_MASK_32 = 23'h00001F;

  // Controller APB map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_WDATA  = 12'h008;
  localparam logic [11:0] REG_RDATA  = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_SWSEL_BIT = 4;
  localparam int CTRL_BEATS_LSB = 8;

  typedef enum logic [2:0] {
    OP_ARRAY_RD, OP_ARRAY_WR, OP_PIN_RD, OP_PIN_WR,
    OP_SW_LOAD, OP_SW_READ, OP_BURST_RD, OP_BURST_WR
  } link_op_t;

  // Next word address of a burst under the bus configuration
  function automatic logic [ADDR_W-1:0] next_word_addr(input logic [ADDR_W-1:0] a,
                                                       input logic [15:0]       cfg);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    begin
      inc = a + 23'h000001;
      case (cfg[2:0])
        BL_CODE_4:  m = BL_MASK_4;
        BL_CODE_8:  m = BL_MASK_8;
        BL_CODE_16: m = BL_MASK_16;
        BL_CODE_32: m = BL_MASK_32;
        default:    m = 23'h000000;
      endcase
      if (cfg[WRAP_BIT] || m == 23'h000000) begin
        next_word_addr = inc;
      end else begin
        next_word_addr = (a & ~m) | (inc & m);
      end
    end
  endfunction : next_word_addr
endpackage : psram_cfg_pkg

// File: hdl/psram_link_if.sv
// Purpose: Pin bundle between memory controller and PSRAM device.
// Assumes: Shared data lines resolved here from both output enables.
// Notes:   Undriven lines read high, as with a weak pull-up.
`timescale 1ns/1ns
interface psram_link_if;
  logic                            link_clk;
  logic                            cs_n;
  logic                            address_valid_n;
  logic                            we_n;
  logic                            oe_n;
  logic                            register_select_pin;
  logic [psram_cfg_pkg::HI_W-1:0]   addr_hi;
  logic [psram_cfg_pkg::DATA_W-1:0] ctl_data_out;
  logic                            ctl_data_oe_n;
  logic [psram_cfg_pkg::DATA_W-1:0] dev_data_out;
  logic                            dev_data_oe_n;
  logic [psram_cfg_pkg::DATA_W-1:0] muxed_addr_data;

  // Wire level of the shared lines
  assign muxed_addr_data = !ctl_data_oe_n ? ctl_data_out :
                           (!dev_data_oe_n ? dev_data_out : 16'hFFFF);

  modport controller (output link_clk, cs_n, address_valid_n, we_n, oe_n, register_select_pin,
                      addr_hi, ctl_data_out, ctl_data_oe_n, input muxed_addr_data);
  modport device (input link_clk, cs_n, address_valid_n, we_n, oe_n, register_select_pin,
                  addr_hi, muxed_addr_data, output dev_data_out, dev_data_oe_n);
endinterface : psram_link_if

// File: sim/psram_config_register_access_bench.sv
// Purpose: Self-checking bench, both link ends, controller driven over APB.
// Assumes: DIV 8, array of 64 words, upper addresses alias.
// Notes:   Model keeps registers and array words in the bench.
`timescale 1ns/1ns
module psram_config_register_access_bench;
  localparam logic [22:0] TOP = psram_cfg_pkg::TOP_ADDR;
  localparam logic [15:0] ID  = 16'h3C96; // Arbitrary identification value
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata, rd, v;
  logic        pready, pslverr;
  logic [15:0] bus_q, refresh_q, mem [64];
  logic [15:0] m_bus     = 16'h9D1F;
  logic [15:0] m_refresh = 16'h0010;
  logic [31:0] seed  = 32'h000031CE;
  logic [22:0] a;
  logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int          n_errors = 0;
  int          checked  = 0;
  int          cycles   = 0;
  int          n, r;

  psram_link_if link ();
  psram_cfg_controller #(.DIV(8)) i_psram_cfg_controller (.link(link.controller), .pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  psram_cfg_device #(.MEM_AW(6), .ID_VALUE(ID)) i_psram_cfg_device (.link(link.device), .pclk(pclk),
    .presetn(presetn), .bus_configuration_q(bus_q), .refresh_configuration_q(refresh_q));
  psram_link_props i_psram_link_props (.pclk(pclk), .presetn(presetn), .link_clk(link.link_clk),
    .cs_n(link.cs_n), .address_valid_n(link.address_valid_n), .we_n(link.we_n), .oe_n(link.oe_n),
    .register_select_pin(link.register_select_pin), .ctl_data_oe_n(link.ctl_data_oe_n),
    .dev_data_oe_n(link.dev_data_oe_n));

  // Clock and hang limit
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Model of the burst address step
  function automatic logic [22:0] step(input logic [22:0] x);
    int len;
    case (m_bus[2:0])
      3'h1: len = 4;
      3'h2: len = 8;
      3'h3: len = 16;
      3'h4: len = 32;
      default: len = 0;
    endcase
    if (m_bus[3] || len == 0) return x + 23'h000001;
    return (x & ~23'(len - 1)) | ((x + 23'h000001) & 23'(len - 1));
  endfunction : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    check(16'(pslverr), 16'(ad > 12'h010 || ad[1:0] != 2'h0), "pslverr");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Start one link operation and wait for idle
  task automatic run(input logic [2:0] op, input logic [22:0] ad, input logic [15:0] d, input int nb,
                     input logic sel);
    logic [31:0] st;
    apb(1'b1, 12'h004, {9'h000, ad}, st);
    apb(1'b1, 12'h008, {16'h0000, d}, st);
    apb(1'b1, 12'h000, {16'h0000, 8'(nb), 3'h0, sel, 1'b0, op}, st);
    st = 32'h00000001;
    while (st[0] !== 1'b0) apb(1'b0, 12'h010, 32'h00000000, st);
    apb(1'b0, 12'h00C, 32'h00000000, rd);
  endtask : run

  task automatic pin_wr(input logic [1:0] c, input logic [15:0] d);
    run(3'h3, {3'h0, c, 18'h00000}, d, 0, 1'b0);
    if (c == 2'h0) m_refresh = d;
    if (c == 2'h2) m_bus = d;
    check(bus_q, m_bus, "bus cfg");
    check(refresh_q, m_refresh, "refresh cfg");
  endtask : pin_wr

  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(bus_q, 16'h9D1F, "bus cfg reset");
    apb(1'b1, 12'h014, 32'hFFFFFFFF, v);
    repeat (3) @(posedge pclk);
    for (int c = 0; c < 4; c++) begin
      run(3'h2, {3'h0, 2'(c), 18'h00000}, 16'h0000, 0, 1'b0);
      if (c != 3) check(rd[15:0], c == 0 ? m_refresh : (c == 1 ? ID : m_bus), "pin read");
      v = rnd();
      pin_wr(2'(c), v[15:0]);
    end
    run(3'h1, TOP, 16'hC3A5, 0, 1'b0);
    mem[63] = 16'hC3A5;
    for (int t = 0; t < 2; t++) begin
      v = rnd();
      run(3'h4, TOP, v[15:0], 0, t[0]);
      if (t == 0) m_refresh = v[15:0];
      else m_bus = v[15:0];
      check(bus_q, m_bus, "sw load bus cfg");
      check(refresh_q, m_refresh, "sw load refresh cfg");
      run(3'h5, TOP, 16'h0000, 0, t[0]);
      check(rd[15:0], t == 0 ? m_refresh : m_bus, "sw read");
      run(3'h2, {3'h0, t[0], 19'h00000}, 16'h0000, 0, 1'b0);
      check(rd[15:0], t == 0 ? m_refresh : m_bus, "pin after sw");
    end
    run(3'h0, TOP, 16'h0000, 0, 1'b0);
    check(rd[15:0], mem[63], "top word");
    // Every burst code with and without wrap
    foreach (codes[k]) for (int w = 0; w < 2; w++) begin
      pin_wr(2'h2, {12'h000, w[0], codes[k]});
      n = codes[k] == 3'h7 ? 6 : 2 << codes[k];
      v = rnd();
      a = codes[k] == 3'h7 ? 23'h7FFFFE : v[22:0];
      run(3'h7, a, v[31:16], n, 1'b0);
      for (int i = 0; i < n; i++) begin
        mem[a[5:0]] = v[31:16] + 16'(i);
        if (i == 0) rd[22:0] = a;
        a = step(a);
      end
      a = rd[22:0];
      r = 1 + int'(rnd() % 32'(n));
      run(3'h6, a, 16'h0000, r, 1'b0);
      repeat (r - 1) a = step(a);
      check(rd[15:0], mem[a[5:0]], "burst word");
    end
    end_of_test();
  end
endmodule : psram_config_register_access_bench

// File: sim/psram_link_props.sv
// Purpose: Link checks between controller and device ends.
// Assumes: Eight pclk per link phase.
// Notes:   Sees the interface wires only.
`timescale 1ns/1ns
module psram_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic address_valid_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic register_select_pin,
  input wire logic ctl_data_oe_n,
  input wire logic dev_data_oe_n
);
  // One domain for every check
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Wire ownership and strobes
  one_driver_a: assert property (ctl_data_oe_n || dev_data_oe_n)
    else $error("Both ends drive the data lines");
  strobe_excl_a: assert property (we_n || oe_n)
    else $error("Write and read strobes low together");
  idle_quiet_a: assert property (cs_n |-> we_n && oe_n && address_valid_n && !link_clk)
    else $error("Strobe or clock active while deselected");
  // Phase lengths and answers
  select_hold_a: assert property ($fell(cs_n) |=> !cs_n [*7])
    else $error("Chip select shorter than one phase");
  addr_phase_a: assert property ($fell(address_valid_n) |-> (!address_valid_n && !ctl_data_oe_n) [*8])
    else $error("Address phase not driven for a phase");
  dev_answer_a: assert property ($fell(dev_data_oe_n) |-> !oe_n && !$past(oe_n, 2))
    else $error("Device drives data without a read strobe");
  sel_stable_a: assert property (!cs_n && $past(!cs_n) |-> $stable(register_select_pin))
    else $error("Register select moved inside an access");
  access_bound_a: assert property ($fell(cs_n) |-> ##[1:900] $rose(cs_n))
    else $error("Access never completed");
endmodule : psram_link_props
